/* ccpms_cfg.svh */
// Constants of the charge port mode sequencer: addresses, fields, resets, timing
// Assumes inclusion by bare name from the package and the design module
`ifndef CCPMS_CFG_SVH
`define CCPMS_CFG_SVH

// ------------------------------------------------------------------------
// Register indices and address width (byte address = index * 4)
// ------------------------------------------------------------------------
`define CCPMS_IDX_CHG_EN        8'h06
`define CCPMS_IDX_DEV_CFG       8'h0A
`define CCPMS_IDX_SEQ_CFG       8'h25
`define CCPMS_IDX_OFF_TIME      8'h30
`define CCPMS_IDX_STATUS        8'h31
`define CCPMS_ADDR_W            8

// ------------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------------
`define CCPMS_F_AUTO_DIS        1
`define CCPMS_F_HICUR           4
`define CCPMS_F_FULL            0
`define CCPMS_F_HANDSET_DIS     1
`define CCPMS_F_ST_PWR          12
`define CCPMS_F_ST_STRAP        16
`define CCPMS_F_ST_SRC          26

// Pin vector layout: {rst_low, straps[9:0], dp[3:0], vdat[3:0]}
`define CCPMS_PIN_W             19
`define CCPMS_P_RST             18
`define CCPMS_P_STRAP           8
`define CCPMS_P_DP              4
`define CCPMS_P_VDAT            0

// Strap vector layout
`define CCPMS_S_CHG             0
`define CCPMS_S_AUTO_DIS        4
`define CCPMS_S_FULL            5
`define CCPMS_S_PPD             6
`define CCPMS_S_GANG            7
`define CCPMS_S_HIF             8
`define CCPMS_S_POL             9

// ------------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------------
`define CCPMS_RST_CHG_EN        4'h0
`define CCPMS_RST_AUTO_DIS      1'h0
`define CCPMS_RST_HICUR         1'h1
`define CCPMS_RST_FULL          1'h0
`define CCPMS_RST_HANDSET_DIS   1'h0

// ------------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------------
`define CCPMS_CLK_MHZ           100
`define CCPMS_OFF_TIME_US       100
`define CCPMS_OFF_CYCLES        (`CCPMS_OFF_TIME_US * `CCPMS_CLK_MHZ)
`define CCPMS_CNT_W             16

`endif

/* ccpms_pkg.sv */
// Types of the charge port mode sequencer
// Assumes ccpms_cfg.svh on the include path
`include "ccpms_cfg.svh"

package ccpms_pkg;

	// Per-port charging mode
	typedef enum logic [2:0]
	{
		CCPMS_IDLE     = 3'b000,
		CCPMS_CDP      = 3'b001,
		CCPMS_DCP      = 3'b010,
		CCPMS_DIV_HIGH = 3'b011,
		CCPMS_DIV_MID  = 3'b100,
		CCPMS_DIV_LOW  = 3'b101,
		CCPMS_HANDSET  = 3'b110,
		CCPMS_PWR_OFF  = 3'b111
	} ccpms_mode_t;

	typedef logic [`CCPMS_CNT_W-1:0] ccpms_cnt_t;

endpackage : ccpms_pkg

/* ccpms_sequencer.sv */
// Four-port charging-mode sequencer with an AHB-Lite register slave
// Assumes one 100 MHz clock, synchronous reset, pins asynchronous to the clock
// What this block does
// - Capture all configuration straps when the global reset pin is released.
// - Upstream limited to high or full/low speed disables SuperSpeed downstream.
// - Upstream limited to full speed disables SuperSpeed and high speed downstream.
// - Charging enabled per port from a four-bit register field or strap pins.
// - Charging downstream mode needs upstream VBUS, configuration and host port power.
// - Unconnected upstream falls back to dedicated charging once others fail.
// - Divider and handset modes only when unconnected and auto sequencing on.
// - Auto sequencing enabled by active-low strap or active-low register bit.
// - Default top divider level is high; select clear limits it to mid unless full sequencing or strap source.
// - Unconnected upstream with charging enabled drives port power active.
// - Auto sequencing off means dedicated charging mode only.
// - Without full sequencing start at top divider, stay until pull-up seen.
// - Pull-up in divider: power off, go handset or dedicated, power on.
// - Pull-up in handset: power off, go dedicated, power on.
// - Pull-up or voltage detect in dedicated: power off, restart dividers.
// - Full sequencing tries every divider level before handset or dedicated.
// - I2C without config memory takes charging selection from straps.
// - Active-low register bit enables the handset mode.

`include "ccpms_cfg.svh"

module ccpms_sequencer #(
	parameter int unsigned OFF_CYCLES = `CCPMS_OFF_CYCLES,
	parameter int unsigned PORTS      = 4
)(
	input  wire logic                i_ref_clk,                     // 100 MHz clock
	input  wire logic                i_rst,                         // Sync reset, high
	input  wire logic                i_global_reset_low,            // Reset pin
	input  wire logic [PORTS-1:0]    i_charge_enable_straps,        // Strap pins
	input  wire logic                i_auto_sequence_disable_strap, // Strap pin
	input  wire logic                i_full_sequence_strap,         // Strap pin
	input  wire logic                i_per_port_power_disable_strap, // Strap pin
	input  wire logic                i_ganged_strap,                // Strap pin
	input  wire logic                i_host_if_select_low,          // Low: SMBus
	input  wire logic                i_power_enable_polarity_strap, // 1: active high
	input  wire logic                i_config_memory_present,       // EEPROM found
	input  wire logic                i_upstream_connected,          // Upstream link up
	input  wire logic                i_upstream_vbus_valid,         // VBUS seen
	input  wire logic                i_hub_configured,              // Hub configured
	input  wire logic [PORTS-1:0]    i_host_port_power,             // Host port power
	input  wire logic                i_upstream_hs_max,             // No SuperSpeed up
	input  wire logic                i_upstream_fs_max,             // Full speed only
	input  wire logic [PORTS-1:0]    i_dp_pullup,                   // D+ pull-up pins
	input  wire logic [PORTS-1:0]    i_data_line_voltage_detect,    // Detect pins
	input  wire logic                hsel,                          // AHB select
	input  wire logic [31:0]         haddr,                         // AHB address
	input  wire logic [1:0]          htrans,                        // AHB transfer
	input  wire logic                hwrite,                        // AHB write
	input  wire logic [2:0]          hsize,                         // AHB size
	input  wire logic                hready,                        // AHB ready in
	input  wire logic [31:0]         hwdata,                        // AHB write data
	output logic      [31:0]         hrdata,                        // AHB read data
	output logic                     hreadyout,                     // Always ready
	output logic                     hresp,                         // Always OKAY
	output logic      [PORTS-1:0]    o_port_power_en,               // Power pins
	output logic      [3*PORTS-1:0]  o_port_mode,                   // Mode per port
	output logic                     o_ss_disable,                  // SuperSpeed off
	output logic                     o_hs_disable                   // High speed off
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned PW = `CCPMS_PIN_W;

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [PW-1:0]                      sa;
		logic [PW-1:0]                      sb;
		logic [PW-1:0]                      sc;
		logic [PW-1:0]                      filt;
		logic                               running;
		logic [9:0]                         strap;
		logic [PORTS-1:0]                   chg_bits;
		logic                               auto_dis_bit;
		logic                               hicur;
		logic                               full_bit;
		logic                               handset_dis_bit;
		ccpms_pkg::ccpms_cnt_t              off_time;
		logic                               wr_pend;
		logic [`CCPMS_ADDR_W-1:0]           wr_addr;
		logic [31:0]                        rdata;
		ccpms_pkg::ccpms_mode_t [PORTS-1:0] mode;
		ccpms_pkg::ccpms_mode_t [PORTS-1:0] pend;
		ccpms_pkg::ccpms_cnt_t [PORTS-1:0]  cnt;
		logic [PORTS-1:0]                   pwr;
		logic [PORTS-1:0]                   pin;
		logic                               ss_dis;
		logic                               hs_dis;
	} ccpms_state_t;

	ccpms_state_t cur;
	ccpms_state_t next_cur;

	localparam ccpms_pkg::ccpms_cnt_t OFF_RST = ccpms_pkg::ccpms_cnt_t'(OFF_CYCLES);
	localparam logic [`CCPMS_ADDR_W-1:0] A_CHG = `CCPMS_ADDR_W'(`CCPMS_IDX_CHG_EN * 4);
	localparam logic [`CCPMS_ADDR_W-1:0] A_DEV = `CCPMS_ADDR_W'(`CCPMS_IDX_DEV_CFG * 4);
	localparam logic [`CCPMS_ADDR_W-1:0] A_SEQ = `CCPMS_ADDR_W'(`CCPMS_IDX_SEQ_CFG * 4);
	localparam logic [`CCPMS_ADDR_W-1:0] A_OFF = `CCPMS_ADDR_W'(`CCPMS_IDX_OFF_TIME * 4);
	localparam logic [`CCPMS_ADDR_W-1:0] A_STA = `CCPMS_ADDR_W'(`CCPMS_IDX_STATUS * 4);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb
	begin
		logic                   use_strap;
		logic [PORTS-1:0]       en;
		logic                   auto_en;
		logic                   full;
		logic                   handset_en;
		ccpms_pkg::ccpms_mode_t start;
		ccpms_pkg::ccpms_mode_t tgt;
		logic                   go_off;
		logic                   dp;
		logic                   vdat;
		logic                   rel;
		logic [`CCPMS_ADDR_W-1:0] a;
		logic                   hit;

		next_cur   = cur;
		use_strap  = 1'b0;
		en         = '0;
		auto_en    = 1'b0;
		full       = 1'b0;
		handset_en = 1'b0;
		start      = ccpms_pkg::CCPMS_DCP;
		tgt        = ccpms_pkg::CCPMS_DCP;
		go_off     = 1'b0;
		dp         = 1'b0;
		vdat       = 1'b0;
		rel        = 1'b0;
		a          = haddr[`CCPMS_ADDR_W-1:0];
		hit        = (haddr[31:`CCPMS_ADDR_W] == '0);

		// Pin synchronisers, change accepted once stages two and three agree
		next_cur.sa = {i_global_reset_low, i_power_enable_polarity_strap,
			i_host_if_select_low, i_ganged_strap, i_per_port_power_disable_strap,
			i_full_sequence_strap, i_auto_sequence_disable_strap,
			i_charge_enable_straps, i_dp_pullup, i_data_line_voltage_detect};
		next_cur.sb = cur.sa;
		next_cur.sc = cur.sb;
		for (int b = 0; b < PW; b++)
		begin
			if (cur.sb[b] == cur.sc[b])
				next_cur.filt[b] = cur.sc[b];
		end

		// Strap capture on release of the reset pin
		rel = cur.filt[`CCPMS_P_RST] & ~cur.running;
		next_cur.running = cur.filt[`CCPMS_P_RST];
		if (rel)
			next_cur.strap = cur.filt[`CCPMS_P_STRAP +: 10];

		// Configuration source select
		use_strap = cur.strap[`CCPMS_S_HIF] & ~i_config_memory_present;
		en = use_strap ? cur.strap[`CCPMS_S_CHG +: PORTS] : cur.chg_bits;
		auto_en = ~(use_strap ? cur.strap[`CCPMS_S_AUTO_DIS] : cur.auto_dis_bit);
		full = use_strap ? cur.strap[`CCPMS_S_FULL] : cur.full_bit;
		handset_en = use_strap | ~cur.handset_dis_bit;
		if (full | use_strap | cur.hicur)
			start = ccpms_pkg::CCPMS_DIV_HIGH;
		else
			start = ccpms_pkg::CCPMS_DIV_MID;

		// Downstream speed limits
		next_cur.ss_dis = i_upstream_hs_max | i_upstream_fs_max;
		next_cur.hs_dis = i_upstream_fs_max;

		// Per-port sequencing
		for (int p = 0; p < PORTS; p++)
		begin
			dp     = cur.filt[`CCPMS_P_DP + p];
			vdat   = cur.filt[`CCPMS_P_VDAT + p];
			go_off = 1'b0;
			tgt    = ccpms_pkg::CCPMS_DCP;
			if (!cur.running || !en[p])
			begin
				next_cur.mode[p] = ccpms_pkg::CCPMS_IDLE;
				next_cur.pwr[p]  = 1'b0;
				next_cur.cnt[p]  = '0;
			end
			else if (i_upstream_connected)
			begin
				next_cur.cnt[p] = '0;
				if (i_upstream_vbus_valid && i_hub_configured && i_host_port_power[p])
				begin
					next_cur.mode[p] = ccpms_pkg::CCPMS_CDP;
					next_cur.pwr[p]  = 1'b1;
				end
				else
				begin
					next_cur.mode[p] = ccpms_pkg::CCPMS_IDLE;
					next_cur.pwr[p]  = 1'b0;
				end
			end
			else
			begin
				next_cur.pwr[p] = 1'b1;
				case (cur.mode[p])
					ccpms_pkg::CCPMS_IDLE,
					ccpms_pkg::CCPMS_CDP:
						next_cur.mode[p] = auto_en ? start : ccpms_pkg::CCPMS_DCP;
					ccpms_pkg::CCPMS_DCP:
					begin
						if (auto_en && (dp || vdat))
						begin
							go_off = 1'b1;
							tgt    = start;
						end
					end
					ccpms_pkg::CCPMS_DIV_HIGH,
					ccpms_pkg::CCPMS_DIV_MID,
					ccpms_pkg::CCPMS_DIV_LOW:
					begin
						if (!auto_en)
							next_cur.mode[p] = ccpms_pkg::CCPMS_DCP;
						else if (dp)
						begin
							go_off = 1'b1;
							if (full && cur.mode[p] != ccpms_pkg::CCPMS_DIV_LOW)
								tgt = ccpms_pkg::ccpms_mode_t'(cur.mode[p] + 3'h1);
							else if (handset_en)
								tgt = ccpms_pkg::CCPMS_HANDSET;
							else
								tgt = ccpms_pkg::CCPMS_DCP;
						end
					end
					ccpms_pkg::CCPMS_HANDSET:
					begin
						if (!auto_en || !handset_en)
							next_cur.mode[p] = ccpms_pkg::CCPMS_DCP;
						else if (dp)
						begin
							go_off = 1'b1;
							tgt    = ccpms_pkg::CCPMS_DCP;
						end
					end
					ccpms_pkg::CCPMS_PWR_OFF:
					begin
						next_cur.pwr[p] = 1'b0;
						if (cur.cnt[p] <= ccpms_pkg::ccpms_cnt_t'(1))
						begin
							next_cur.mode[p] = cur.pend[p];
							next_cur.pwr[p]  = 1'b1;
							next_cur.cnt[p]  = '0;
						end
						else
							next_cur.cnt[p] = cur.cnt[p] - ccpms_pkg::ccpms_cnt_t'(1);
					end
					default:
						next_cur.mode[p] = ccpms_pkg::CCPMS_IDLE;
				endcase
				if (go_off)
				begin
					next_cur.mode[p] = ccpms_pkg::CCPMS_PWR_OFF;
					next_cur.pend[p] = tgt;
					next_cur.cnt[p]  = cur.off_time;
					next_cur.pwr[p]  = 1'b0;
				end
			end
			next_cur.pin[p] = next_cur.pwr[p] ~^ next_cur.strap[`CCPMS_S_POL];
		end

		// AHB-Lite data phase write
		next_cur.wr_pend = 1'b0;
		if (cur.wr_pend)
		begin
			case (cur.wr_addr)
				A_CHG: next_cur.chg_bits = hwdata[PORTS-1:0];
				A_DEV:
				begin
					next_cur.auto_dis_bit = hwdata[`CCPMS_F_AUTO_DIS];
					next_cur.hicur        = hwdata[`CCPMS_F_HICUR];
				end
				A_SEQ:
				begin
					next_cur.full_bit        = hwdata[`CCPMS_F_FULL];
					next_cur.handset_dis_bit = hwdata[`CCPMS_F_HANDSET_DIS];
				end
				A_OFF: next_cur.off_time = hwdata[`CCPMS_CNT_W-1:0];
				default: next_cur.off_time = cur.off_time;
			endcase
		end

		// AHB-Lite address phase, read data prepared for the data phase
		if (hsel && hready && htrans[1])
		begin
			next_cur.rdata = '0;
			if (hwrite)
			begin
				next_cur.wr_pend = hit;
				next_cur.wr_addr = a;
			end
			else if (hit)
			begin
				case (a)
					A_CHG: next_cur.rdata[PORTS-1:0] = cur.chg_bits;
					A_DEV:
					begin
						next_cur.rdata[`CCPMS_F_AUTO_DIS] = cur.auto_dis_bit;
						next_cur.rdata[`CCPMS_F_HICUR]    = cur.hicur;
					end
					A_SEQ:
					begin
						next_cur.rdata[`CCPMS_F_FULL]        = cur.full_bit;
						next_cur.rdata[`CCPMS_F_HANDSET_DIS] = cur.handset_dis_bit;
					end
					A_OFF: next_cur.rdata[`CCPMS_CNT_W-1:0] = cur.off_time;
					A_STA:
					begin
						next_cur.rdata[3*PORTS-1:0] = cur.mode;
						next_cur.rdata[`CCPMS_F_ST_PWR +: PORTS] = cur.pwr;
						next_cur.rdata[`CCPMS_F_ST_STRAP +: 10]  = cur.strap;
						next_cur.rdata[`CCPMS_F_ST_SRC]          = use_strap;
					end
					default: next_cur.rdata = '0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			cur                 <= '0;
			cur.chg_bits        <= `CCPMS_RST_CHG_EN;
			cur.auto_dis_bit    <= `CCPMS_RST_AUTO_DIS;
			cur.hicur           <= `CCPMS_RST_HICUR;
			cur.full_bit        <= `CCPMS_RST_FULL;
			cur.handset_dis_bit <= `CCPMS_RST_HANDSET_DIS;
			cur.off_time        <= OFF_RST;
		end
		else
			cur <= next_cur;
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign hrdata          = cur.rdata;
	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;
	assign o_port_power_en = cur.pin;
	assign o_port_mode     = cur.mode;
	assign o_ss_disable    = cur.ss_dis;
	assign o_hs_disable    = cur.hs_dis;

endmodule : ccpms_sequencer

/* ccpms_seq_assertions.sv */
// Port-level checker of the charge port mode sequencer
// Assumes bind onto ccpms_sequencer built with four ports
module ccpms_seq_chk #(
	parameter int unsigned OFF_CYCLES = 8
)(
	input wire logic        i_ref_clk,                     // Clock
	input wire logic        i_rst,                         // Sync reset
	input wire logic        i_power_enable_polarity_strap, // Polarity pin
	input wire logic        i_upstream_connected,          // Upstream link
	input wire logic        i_upstream_vbus_valid,         // VBUS seen
	input wire logic        i_hub_configured,              // Configured
	input wire logic [3:0]  i_host_port_power,             // Host power
	input wire logic        i_upstream_hs_max,             // No SuperSpeed
	input wire logic        i_upstream_fs_max,             // Full speed only
	input wire logic [3:0]  o_port_power_en,               // Power pins
	input wire logic [11:0] o_port_mode,                   // Modes
	input wire logic        o_ss_disable,                  // SuperSpeed off
	input wire logic        o_hs_disable                   // High speed off
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0]  m0;
	logic [15:0] cnt;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	// ----------------------------------------------------------------
	// Port 0 power-off length
	// ----------------------------------------------------------------
	assign m0 = o_port_mode[2:0];
	always_ff @(posedge i_ref_clk)
		cnt <= (i_rst || m0 != 3'h7) ? 16'h0000 : cnt + 16'h0001;

	a_ss_follow_up: assert property (!$past(i_rst) |->
		o_ss_disable == $past(i_upstream_hs_max || i_upstream_fs_max))
		else $error("superspeed disable wrong");
	a_hs_follow_up: assert property (!$past(i_rst) |->
		o_hs_disable == $past(i_upstream_fs_max))
		else $error("high speed disable wrong");
	a_off_power_low: assert property (m0 == 3'h7 |->
		o_port_power_en[0] == !i_power_enable_polarity_strap)
		else $error("power active in off interval");
	a_off_length: assert property ($fell(m0 == 3'h7) && !(m0 inside {3'h0, 3'h1}) |->
		int'(cnt) == OFF_CYCLES)
		else $error("off interval length wrong");
	a_cdp_gated: assert property (m0 == 3'h1 |-> $past(i_upstream_connected &&
		i_upstream_vbus_valid && i_hub_configured && i_host_port_power[0]))
		else $error("charging downstream mode without its conditions");
	a_no_custom_up: assert property (i_upstream_connected [*8] |->
		!(m0 inside {[3'h3:3'h6]}))
		else $error("custom mode while upstream connected");
	a_entry_after_off: assert property ($changed(m0) && (m0 inside {[3'h2:3'h6]}) |->
		$past(m0) inside {3'h0, 3'h1, 3'h7})
		else $error("mode change without power cycle");
	a_off_cause: assert property ($rose(m0 == 3'h7) |->
		$past(m0) inside {[3'h2:3'h6]})
		else $error("off interval from wrong mode");
endmodule : ccpms_seq_chk

bind ccpms_sequencer ccpms_seq_chk #(.OFF_CYCLES(OFF_CYCLES)) u_chk (.i_ref_clk, .i_rst,
	.i_power_enable_polarity_strap, .i_upstream_connected, .i_upstream_vbus_valid,
	.i_hub_configured, .i_host_port_power, .i_upstream_hs_max, .i_upstream_fs_max,
	.o_port_power_en, .o_port_mode, .o_ss_disable, .o_hs_disable);

/* ccpms_phone_model.sv */
// Portable device model on the four downstream charging ports
// Assumes power enables handed over active high
module ccpms_phone_model #(
	parameter int unsigned DELAY = 20
)(
	input  wire logic       i_ref_clk,   // Clock
	input  wire logic       i_rst,       // Sync reset
	input  wire logic [3:0] i_power_on,  // Port powered
	input  wire logic [3:0] i_attach,    // Device plugged in
	input  wire logic       i_use_vdat,  // Signal by voltage detect
	output logic      [3:0] o_dp_pullup, // D+ pull-up
	output logic      [3:0] o_vdat       // Voltage detect
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned wait_cnt [4];

	// Device pulls up D+, or drives voltage detect, some time after power comes, drops it when unpowered
	always_ff @(posedge i_ref_clk)
	begin
		for (int p = 0; p < 4; p++)
		begin
			if (i_rst || !i_power_on[p] || !i_attach[p])
			begin
				wait_cnt[p] <= 0;
				o_dp_pullup[p] <= 1'b0;
				o_vdat[p] <= 1'b0;
			end
			else if (wait_cnt[p] < DELAY)
				wait_cnt[p] <= wait_cnt[p] + 1;
			else
			begin
				o_dp_pullup[p] <= !i_use_vdat;
				o_vdat[p] <= i_use_vdat;
			end
		end
	end
endmodule : ccpms_phone_model

/* tb.sv */
// Self-checking bench of the charge port mode sequencer
// Assumes the phone model on the ports and the bound checker
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned OFF = 8;
	localparam int          RST_HOLD = 30;
	logic        i_ref_clk = 1'b0, i_rst = 1'b1, grst_low = 1'b0;
	logic [3:0]  chg_s = 4'hA, hostpwr = 4'h0, attach = 4'h0;
	logic        auto_s = 1'b0, gang_s = 1'b1, hif_s = 1'b0, use_vdat = 1'b0;
	logic        full_s = 1'b0, pol_s = 1'b1, cfgmem = 1'b0;
	logic        up_con = 1'b0, vbus = 1'b0, cfgd = 1'b0, hs_max = 1'b0, fs_max = 1'b0;
	logic        hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic        hreadyout, hresp, ss_dis, hs_dis;
	logic [3:0]  pwr, dp, vdat;
	logic [11:0] mode;
	logic [2:0]  seq_q[$];
	logic [2:0]  last0 = 3'h0;
	int          bad_count = 0, n_checks = 0, cycles = 0;

	initial forever #5 i_ref_clk = ~i_ref_clk;

	ccpms_sequencer #(.OFF_CYCLES(OFF)) u_dut (.i_ref_clk, .i_rst,
		.i_global_reset_low(grst_low), .i_charge_enable_straps(chg_s),
		.i_auto_sequence_disable_strap(auto_s), .i_full_sequence_strap(full_s),
		.i_per_port_power_disable_strap(gang_s), .i_ganged_strap(gang_s),
		.i_host_if_select_low(hif_s), .i_power_enable_polarity_strap(pol_s),
		.i_config_memory_present(cfgmem), .i_upstream_connected(up_con),
		.i_upstream_vbus_valid(vbus), .i_hub_configured(cfgd), .i_host_port_power(hostpwr),
		.i_upstream_hs_max(hs_max), .i_upstream_fs_max(fs_max), .i_dp_pullup(dp),
		.i_data_line_voltage_detect(vdat), .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.o_port_power_en(pwr), .o_port_mode(mode), .o_ss_disable(ss_dis),
		.o_hs_disable(hs_dis));
	ccpms_phone_model u_phone (.i_ref_clk, .i_rst, .i_power_on(pwr), .i_attach(attach),
		.i_use_vdat(use_vdat), .o_dp_pullup(dp), .o_vdat(vdat));

	// ----------------------------------------------------------------
	// Bus cycles and checks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge i_ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge i_ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] t;
		ahb(1'b1, a, d, t);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(d & m, e);
	endtask : rd_chk

	task automatic wait_mode(input int p, input logic [2:0] m);
		for (int i = 0; i < 300 && mode[3*p+:3] !== m; i++)
			@(posedge i_ref_clk);
		chk(mode[3*p+:3], m);
	endtask : wait_mode

	// Port 0 sequence from idle, one digit per mode
	task automatic run_seq(input logic [31:0] c28, input logic [31:0] c94,
		input logic vd, input string s);
		wr(32'h18, 32'h0);
		wait_mode(0, 3'h0);
		wr(32'h28, c28);
		wr(32'h94, c94);
		use_vdat <= vd;
		attach <= 4'h1;
		seq_q.delete();
		wr(32'h18, 32'h1);
		repeat (600) @(posedge i_ref_clk);
		chk(seq_q.size() >= s.len(), 1);
		for (int i = 0; i < s.len() && i < seq_q.size(); i++)
			chk(seq_q[i], s[i] - 8'h30);
	endtask : run_seq

	task automatic end_sim();
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	always @(posedge i_ref_clk)
		if (mode[2:0] !== last0)
		begin
			last0 <= mode[2:0];
			if (mode[2:0] !== 3'h0)
				seq_q.push_back(mode[2:0]);
		end

	always @(posedge i_ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		rd_chk(32'h18, 32'hF, 32'h0);
		rd_chk(32'h28, 32'h12, 32'h10);
		rd_chk(32'h94, 32'h3, 32'h0);
		rd_chk(32'h200, 32'hFFFFFFFF, 32'h0);
		chk(hresp, 32'h0);
		wr(32'hC0, OFF);
		rd_chk(32'hC0, 32'hFFFF, OFF);
		repeat (RST_HOLD) @(posedge i_ref_clk);
		grst_low <= 1'b1;
		repeat (10) @(posedge i_ref_clk);
		chg_s <= 4'h5;
		gang_s <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
		rd_chk(32'hC4, 32'h07FF0000, 32'h02CA0000);
		hs_max <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		chk({ss_dis, hs_dis}, 2'b10);
		hs_max <= 1'b0;
		fs_max <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		chk({ss_dis, hs_dis}, 2'b11);
		fs_max <= 1'b0;
		wr(32'h28, 32'h12);
		wr(32'h18, 32'h5);
		wait_mode(0, 3'h2);
		wait_mode(2, 3'h2);
		wait_mode(1, 3'h0);
		chk(pwr, 4'h5);
		rd_chk(32'hC4, 32'hFFFF, 32'h5082);
		up_con <= 1'b1;
		vbus <= 1'b1;
		cfgd <= 1'b1;
		hostpwr <= 4'h1;
		wait_mode(0, 3'h1);
		wait_mode(2, 3'h0);
		vbus <= 1'b0;
		wait_mode(0, 3'h0);
		wr(32'h18, 32'h0);
		up_con <= 1'b0;
		run_seq(32'h10, 32'h0, 1'b0, "3767273");
		run_seq(32'h00, 32'h0, 1'b0, "4767274");
		run_seq(32'h10, 32'h1, 1'b0, "37475767273");
		run_seq(32'h10, 32'h2, 1'b0, "37273");
		run_seq(32'h10, 32'h2, 1'b1, "3");
		chk(seq_q.size(), 1);
		attach <= 4'h0;
		hif_s <= 1'b1;
		auto_s <= 1'b1;
		chg_s <= 4'h3;
		full_s <= 1'b1;
		pol_s <= 1'b0;
		grst_low <= 1'b0;
		repeat (RST_HOLD) @(posedge i_ref_clk);
		grst_low <= 1'b1;
		wait_mode(1, 3'h2);
		chk(pwr, 4'hC);
		rd_chk(32'hC4, 32'h07FF0000, 32'h05330000);
		cfgmem <= 1'b1;
		rd_chk(32'hC4, 32'h04000000, 32'h0);
		end_sim();
	end
endmodule : tb
